/* File: sgoc_defs.vh */
`ifndef SGOC_DEFS_VH
`define SGOC_DEFS_VH
// object types
`define SGOC_TYPE_WITHDRAWABLE 2'h0
`define SGOC_TYPE_BREAKER      2'h1
`define SGOC_TYPE_MOTOR_DISC   2'h2
`define SGOC_TYPE_EARTH_SWITCH 2'h3
// breaker position codes
`define SGOC_POS_INTERMEDIATE  2'h0
`define SGOC_POS_OPEN          2'h1
`define SGOC_POS_CLOSED        2'h2
`define SGOC_POS_BAD           2'h3
// cart position codes
`define SGOC_CART_BETWEEN      3'h0
`define SGOC_CART_WITHDRAWN    3'h1
`define SGOC_CART_INSERTED     3'h2
`define SGOC_CART_INVALID      3'h3
`define SGOC_CART_NOT_IN_USE   3'h4
// ready supervision
`define SGOC_RDY_NOT_USED      2'h0
`define SGOC_RDY_HIGH          2'h1
`define SGOC_RDY_LOW           2'h2
// forced status selections
`define SGOC_FORCE_NORMAL      4'h0
`define SGOC_FORCE_OPEN_REQ    4'h1
`define SGOC_FORCE_CLOSE_REQ   4'h2
`define SGOC_FORCE_OPEN_SIG    4'h3
`define SGOC_FORCE_CLOSE_SIG   4'h4
`define SGOC_FORCE_WAIT_RDY    4'h5
`define SGOC_FORCE_WAIT_SYNC   4'h6
`define SGOC_FORCE_RDY_FAIL    4'h7
`define SGOC_FORCE_SYNC_FAIL   4'h8
`define SGOC_FORCE_OPEN_TOUT   4'h9
`define SGOC_FORCE_CLOSE_TOUT  4'ha
`define SGOC_FORCE_USER_OPEN   4'hb
`define SGOC_FORCE_USER_CLOSE  4'hc
// register offsets
`define SGOC_REG_CTRL          4'h0
`define SGOC_REG_STATUS        4'h1
`define SGOC_REG_OPEN_OK       4'h2
`define SGOC_REG_CLOSE_OK      4'h3
`define SGOC_REG_OPEN_FAIL     4'h4
`define SGOC_REG_CLOSE_FAIL    4'h5
`define SGOC_REG_REMOTE_CMD    4'h6
// remote command register bits
`define SGOC_RCMD_OPEN         0
`define SGOC_RCMD_CLOSE        1
`define SGOC_RCMD_SELECT       2
`define SGOC_RCMD_CANCEL       3
// ctrl register bits
`define SGOC_CTRL_CLEAR        0
// timing
`define SGOC_CLK_MHZ           250
`define SGOC_OP_TIME_MS        200
`define SGOC_SEL_TIME_MS       30000
`define SGOC_PULSE_TIME_MS     100
`endif

/* File: sgoc_pos_decode.v */
`timescale 1ns/100ps
`include "sgoc_defs.vh"
module sgoc_pos_decode (
  // feedback
  input  wire       open_in,
  input  wire       close_in,
  input  wire       single_input,
  // cart
  input  wire       cart_in_fb,
  input  wire       cart_out_fb,
  input  wire [1:0] object_type,
  // decoded
  output reg  [1:0] position,
  output reg  [2:0] cart_state
);
  reg open_eff;
  reg close_eff;
  always @* begin
    open_eff  = open_in;
    close_eff = single_input ? ~open_in : close_in;
    case ({close_eff, open_eff})
      2'b00:   position = `SGOC_POS_INTERMEDIATE;
      2'b01:   position = `SGOC_POS_OPEN;
      2'b10:   position = `SGOC_POS_CLOSED;
      default: position = `SGOC_POS_BAD;
    endcase
    if (object_type != `SGOC_TYPE_WITHDRAWABLE) begin
      cart_state = `SGOC_CART_NOT_IN_USE;
    end else begin
      case ({cart_in_fb, cart_out_fb})
        2'b00:   cart_state = `SGOC_CART_BETWEEN;
        2'b01:   cart_state = `SGOC_CART_WITHDRAWN;
        2'b10:   cart_state = `SGOC_CART_INSERTED;
        default: cart_state = `SGOC_CART_INVALID;
      endcase
    end
  end
endmodule // sgoc_pos_decode

/* File: sgoc_object_control.v */
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "sgoc_defs.vh"
module sgoc_object_control #(
  parameter         CNT_W      = 32,
  parameter integer OP_CYCLES  = `SGOC_OP_TIME_MS * 1000 * `SGOC_CLK_MHZ,
  parameter [39:0]  SEL_CYCLES = `SGOC_SEL_TIME_MS * 1000 * `SGOC_CLK_MHZ
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // register port
  input  wire [3:0]       reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_write,
  input  wire             reg_read,
  output reg  [31:0]      reg_rdata,
  // static configuration
  input  wire [1:0]       object_type,
  input  wire             single_input,
  input  wire             use_sync,
  input  wire [1:0]       use_ready,
  input  wire             force_enable,
  input  wire [3:0]       force_state,
  input  wire             remote_select_mode,
  // local/remote selector, high is remote
  input  wire             remote_mode,
  // command sources
  input  wire             local_open,
  input  wire             local_close,
  input  wire             auto_open,
  input  wire             auto_close,
  input  wire             open_block,
  input  wire             close_block,
  // feedback
  input  wire             open_fb,
  input  wire             close_fb,
  input  wire             cart_in_fb,
  input  wire             cart_out_fb,
  input  wire             ready_in,
  input  wire             sync_in,
  // contacts and status
  output reg              object_open,
  output reg              object_close,
  output wire [1:0]       position,
  output wire [2:0]       cart_state,
  output reg  [3:0]       object_status,
  output reg              open_allowed,
  output reg              close_allowed,
  output reg              object_ready,
  output reg              sync_ok,
  output reg              open_timeout,
  output reg              close_timeout
);
  localparam ST_IDLE       = 3'h0;
  localparam ST_OPENING    = 3'h1;
  localparam ST_CLOSING    = 3'h2;
  localparam ST_WAIT_CLOSE = 3'h3;
  localparam ST_DONE       = 3'h4;

  reg  [2:0]       state;
  reg  [31:0]      timer;
  reg  [39:0]      sel_timer;
  reg              selected;
  reg  [CNT_W-1:0] open_ok_cnt;
  reg  [CNT_W-1:0] close_ok_cnt;
  reg  [CNT_W-1:0] open_fail_cnt;
  reg  [CNT_W-1:0] close_fail_cnt;
  reg              clear_pending;
  reg              rem_open;
  reg              rem_close;
  reg  [3:0]       live_status;
  reg              ready_ok;
  wire             monitor_only;
  wire             req_open;
  wire             req_close;
  wire             wr_cmd;
  wire             wr_ctrl;
  wire             counts_cleared;

  function [CNT_W-1:0] bump;
    input [CNT_W-1:0] v;
    begin
      bump = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  sgoc_pos_decode u_decode (
    .open_in      (open_fb),
    .close_in     (close_fb),
    .single_input (single_input),
    .cart_in_fb   (cart_in_fb),
    .cart_out_fb  (cart_out_fb),
    .object_type  (object_type),
    .position     (position),
    .cart_state   (cart_state)
  );

  // the earth switch is only indicated, never driven
  assign monitor_only = (object_type == `SGOC_TYPE_EARTH_SWITCH);
  assign wr_cmd  = reg_write && (reg_addr == `SGOC_REG_REMOTE_CMD);
  assign wr_ctrl = reg_write && (reg_addr == `SGOC_REG_CTRL);
  assign counts_cleared = clear_pending;

  // remote commands; in select mode an execute needs a live selection
  always @* begin
    rem_open  = 1'b0;
    rem_close = 1'b0;
    if (wr_cmd && remote_mode && (!remote_select_mode || selected)) begin
      rem_open  = reg_wdata[`SGOC_RCMD_OPEN];
      rem_close = reg_wdata[`SGOC_RCMD_CLOSE];
    end
  end

  // automatic sources act regardless of the selector
  assign req_open  = (rem_open || auto_open ||
                      (local_open && !remote_mode)) && !monitor_only;
  assign req_close = (rem_close || auto_close ||
                      (local_close && !remote_mode)) && !monitor_only;

  // ready check on close applies to every type except the motor disconnector
  always @* begin
    case (use_ready)
      `SGOC_RDY_HIGH: ready_ok = ready_in;
      `SGOC_RDY_LOW:  ready_ok = ~ready_in;
      default:        ready_ok = 1'b1;
    endcase
    if (object_type == `SGOC_TYPE_MOTOR_DISC) begin
      ready_ok = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selected  <= 1'b0;
      sel_timer <= 40'h0;
    end else if (wr_cmd && remote_mode) begin
      if (reg_wdata[`SGOC_RCMD_SELECT]) begin
        selected  <= 1'b1;
        sel_timer <= SEL_CYCLES;
      end else begin
        selected  <= 1'b0;
        sel_timer <= 40'h0;
      end
    end else if (selected) begin
      // an unexecuted selection lapses so a stale select cannot fire later
      if (sel_timer == 40'h0 || !remote_mode) begin
        selected <= 1'b0;
      end else begin
        sel_timer <= sel_timer - 40'h1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      timer          <= 32'h0;
      object_open    <= 1'b0;
      object_close   <= 1'b0;
      open_timeout   <= 1'b0;
      close_timeout  <= 1'b0;
      live_status    <= `SGOC_FORCE_NORMAL;
      open_ok_cnt    <= {CNT_W{1'b0}};
      close_ok_cnt   <= {CNT_W{1'b0}};
      open_fail_cnt  <= {CNT_W{1'b0}};
      close_fail_cnt <= {CNT_W{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          live_status <= `SGOC_FORCE_NORMAL;
          if (req_open && !open_block) begin
            state        <= ST_OPENING;
            timer        <= OP_CYCLES;
            object_open  <= 1'b1;
            open_timeout <= 1'b0;
            live_status  <= `SGOC_FORCE_OPEN_SIG;
          end else if (req_close && !close_block) begin
            state         <= ST_WAIT_CLOSE;
            timer         <= OP_CYCLES;
            close_timeout <= 1'b0;
            live_status   <= `SGOC_FORCE_CLOSE_REQ;
          end
        end
        ST_WAIT_CLOSE: begin
          if (close_block || !ready_ok || (use_sync && !sync_in)) begin
            live_status <= !ready_ok ? `SGOC_FORCE_WAIT_RDY
                                     : `SGOC_FORCE_WAIT_SYNC;
            if (timer == 32'h0) begin
              state       <= ST_DONE;
              close_fail_cnt <= bump(close_fail_cnt);
              live_status <= !ready_ok ? `SGOC_FORCE_RDY_FAIL
                                       : `SGOC_FORCE_SYNC_FAIL;
            end else begin
              timer <= timer - 32'h1;
            end
          end else begin
            state        <= ST_CLOSING;
            timer        <= OP_CYCLES;
            object_close <= 1'b1;
            live_status  <= `SGOC_FORCE_CLOSE_SIG;
          end
        end
        ST_OPENING: begin
          if (position == `SGOC_POS_OPEN) begin
            state       <= ST_DONE;
            object_open <= 1'b0;
            open_ok_cnt <= bump(open_ok_cnt);
          end else if (timer == 32'h0) begin
            state         <= ST_DONE;
            object_open   <= 1'b0;
            open_timeout  <= 1'b1;
            open_fail_cnt <= bump(open_fail_cnt);
            live_status   <= `SGOC_FORCE_OPEN_TOUT;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_CLOSING: begin
          if (position == `SGOC_POS_CLOSED) begin
            state        <= ST_DONE;
            object_close <= 1'b0;
            close_ok_cnt <= bump(close_ok_cnt);
          end else if (timer == 32'h0) begin
            state          <= ST_DONE;
            object_close   <= 1'b0;
            close_timeout  <= 1'b1;
            close_fail_cnt <= bump(close_fail_cnt);
            live_status    <= `SGOC_FORCE_CLOSE_TOUT;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state        <= ST_IDLE;
          object_open  <= 1'b0;
          object_close <= 1'b0;
        end
      endcase
      // clear is applied after counting, so it wins that cycle
      if (counts_cleared) begin
        open_ok_cnt    <= {CNT_W{1'b0}};
        close_ok_cnt   <= {CNT_W{1'b0}};
        open_fail_cnt  <= {CNT_W{1'b0}};
        close_fail_cnt <= {CNT_W{1'b0}};
      end
    end
  end

  // clear control returns to idle by itself after one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_pending <= 1'b0;
    end else begin
      clear_pending <= wr_ctrl && reg_wdata[`SGOC_CTRL_CLEAR];
    end
  end

  // configuration is sampled live; it is assumed static outside setup
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      object_status <= `SGOC_FORCE_NORMAL;
      open_allowed  <= 1'b0;
      close_allowed <= 1'b0;
      object_ready  <= 1'b0;
      sync_ok       <= 1'b0;
    end else begin
      object_status <= force_enable ? force_state : live_status;
      open_allowed  <= !open_block && !monitor_only;
      close_allowed <= !close_block && !monitor_only;
      object_ready  <= ready_ok;
      sync_ok       <= !use_sync || sync_in;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      case (reg_addr)
        `SGOC_REG_CTRL:       reg_rdata <= {31'h0, clear_pending};
        `SGOC_REG_STATUS:     reg_rdata <= {16'h0, object_status,
                                            1'b0, cart_state, position,
                                            open_timeout, close_timeout,
                                            open_allowed, close_allowed,
                                            object_ready, sync_ok};
        `SGOC_REG_OPEN_OK:    reg_rdata <= open_ok_cnt;
        `SGOC_REG_CLOSE_OK:   reg_rdata <= close_ok_cnt;
        `SGOC_REG_OPEN_FAIL:  reg_rdata <= open_fail_cnt;
        `SGOC_REG_CLOSE_FAIL: reg_rdata <= close_fail_cnt;
        `SGOC_REG_REMOTE_CMD: reg_rdata <= {31'h0, selected};
        default:              reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // sgoc_object_control

/* File: sgoc_object_control_props.sv */
`timescale 1ns/100ps
`include "sgoc_defs.vh"
module sgoc_object_control_props (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // configuration and feedback
  input wire [1:0] object_type,
  input wire       single_input,
  input wire       use_sync,
  input wire [1:0] use_ready,
  input wire       ready_in,
  input wire       close_block,
  input wire       open_fb,
  input wire       close_fb,
  input wire       cart_in_fb,
  input wire       cart_out_fb,
  input wire       sync_in,
  // outputs
  input wire       object_open,
  input wire       object_close,
  input wire [1:0] position,
  input wire [2:0] cart_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_one_contact: assert property (!(object_open && object_close))
    else $error("open and close driven together");
  chk_pos_decode: assert property (
    !single_input |-> position == {close_fb, open_fb})
    else $error("position decode wrong");
  chk_single_fb: assert property (
    single_input |-> position == {~open_fb, open_fb})
    else $error("single input decode wrong");
  chk_cart_unused: assert property (
    object_type != `SGOC_TYPE_WITHDRAWABLE
    |-> cart_state == `SGOC_CART_NOT_IN_USE)
    else $error("cart not reported unused");
  chk_cart_bad: assert property (
    object_type == `SGOC_TYPE_WITHDRAWABLE && cart_in_fb && cart_out_fb
    |-> cart_state == `SGOC_CART_INVALID)
    else $error("cart invalid not reported");
  chk_earth_idle: assert property (
    object_type == `SGOC_TYPE_EARTH_SWITCH |-> !object_open && !object_close)
    else $error("earth switch driven");
  chk_sync_gate: assert property (
    $rose(object_close) |-> !$past(use_sync) || $past(sync_in))
    else $error("close without sync");
  chk_block_gate: assert property (
    $rose(object_close) |-> !$past(close_block))
    else $error("blocked close executed");
  chk_ready_gate: assert property (
    $rose(object_close) && $past(object_type) != `SGOC_TYPE_MOTOR_DISC
    |-> ($past(use_ready) != `SGOC_RDY_HIGH || $past(ready_in)) &&
        ($past(use_ready) != `SGOC_RDY_LOW || !$past(ready_in)))
    else $error("close without ready");
  chk_open_ends: assert property (
    object_open && position == `SGOC_POS_OPEN |=> !object_open)
    else $error("open contact held after open");
  cov_open: cover property ($rose(object_open));
  cov_close: cover property ($rose(object_close));
  cov_cart_bad: cover property (cart_state == `SGOC_CART_INVALID);
endmodule // sgoc_object_control_props

bind sgoc_object_control sgoc_object_control_props u_props (
  .clk(clk), .rst_n(rst_n), .object_type(object_type),
  .single_input(single_input), .use_sync(use_sync),
  .use_ready(use_ready), .ready_in(ready_in),
  .close_block(close_block), .open_fb(open_fb), .close_fb(close_fb),
  .cart_in_fb(cart_in_fb), .cart_out_fb(cart_out_fb), .sync_in(sync_in),
  .object_open(object_open), .object_close(object_close),
  .position(position), .cart_state(cart_state)
);

/* File: sgoc_breaker_model.sv */
`timescale 1ns/100ps
module sgoc_breaker_model #(
  parameter LAT = 3
) (
  // contacts
  input  wire clk,
  input  wire object_open,
  input  wire object_close,
  input  wire stuck,
  // feedback
  output reg  open_fb,
  output reg  close_fb
);
  integer cnt;
  initial begin
    cnt = 0;
    open_fb = 1'h0;
    close_fb = 1'h1;
  end
  // leaves its end stop first, so the monitor sees intermediate in travel when single_input is low
  always @(posedge clk) begin
    cnt <= (object_open | object_close) ? cnt + 1 : 0;
    if (!stuck && cnt == 0 && (object_open | object_close)) begin
      open_fb <= 1'h0;
      close_fb <= 1'h0;
    end
    if (!stuck && cnt == LAT) begin
      open_fb <= object_open;
      close_fb <= object_close;
    end
  end
endmodule // sgoc_breaker_model

/* File: test_switchgear_object_control.sv */
`timescale 1ns/100ps
`include "sgoc_defs.vh"
module test_switchgear_object_control;
  reg         clk, rst_n, reg_write, reg_read, so, sc, stuck, single_input;
  reg         use_sync, force_enable, remote_select_mode, remote_mode;
  reg         local_open, local_close, auto_close, close_block;
  reg         auto_open, open_block, ready_in;
  reg         cart_in_fb, cart_out_fb, sync_in;
  reg  [3:0]  reg_addr, force_state;
  reg  [31:0] reg_wdata, rv;
  reg  [1:0]  object_type, use_ready;
  wire        open_fb, close_fb, object_open, object_close, close_timeout;
  wire [31:0] reg_rdata;
  wire [1:0]  position;
  wire [2:0]  cart_state;
  integer     err_total, samples_checked, i;
  sgoc_object_control #(.OP_CYCLES(20), .SEL_CYCLES(50)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .object_type(object_type),
    .single_input(single_input), .use_sync(use_sync), .use_ready(use_ready),
    .force_enable(force_enable), .force_state(force_state),
    .remote_select_mode(remote_select_mode), .remote_mode(remote_mode),
    .local_open(local_open), .local_close(local_close),
    .auto_open(auto_open), .auto_close(auto_close),
    .open_block(open_block),
    .close_block(close_block), .open_fb(open_fb), .close_fb(close_fb),
    .cart_in_fb(cart_in_fb), .cart_out_fb(cart_out_fb),
    .ready_in(ready_in), .sync_in(sync_in), .object_open(object_open),
    .object_close(object_close), .position(position),
    .cart_state(cart_state), .object_status(), .open_allowed(),
    .close_allowed(), .object_ready(), .sync_ok(), .open_timeout(),
    .close_timeout(close_timeout));
  sgoc_breaker_model #(.LAT(3)) u_brk (.clk(clk), .object_open(object_open),
    .object_close(object_close), .stuck(stuck), .open_fb(open_fb),
    .close_fb(close_fb));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clk);
      reg_write <= 1'h0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clk);
      reg_read <= 1'h0;
      #1 rv = reg_rdata;
    end
  endtask
  task watch(input integer n);
    begin
      so = 1'h0;
      sc = 1'h0;
      repeat (n) begin
        @(posedge clk);
        #1 so = so | object_open;
        sc = sc | object_close;
      end
    end
  endtask
  // w: 0 local open, 1 local close, 2 automatic close, 3 automatic open
  task pulse(input integer w);
    begin
      @(posedge clk);
      local_open <= (w == 0);
      local_close <= (w == 1);
      auto_close <= (w == 2);
      auto_open <= (w == 3);
      @(posedge clk);
      {local_open, local_close, auto_close, auto_open} <= 4'h0;
    end
  endtask
  task t_open;
    begin
      @(posedge clk);
      single_input <= 1'h1;
      wr(`SGOC_REG_REMOTE_CMD, 32'h1);
      @(posedge clk);
      #1 chk(object_open, 1'h1);
      watch(12);
      chk(sc, 1'h0);
      chk(position, `SGOC_POS_OPEN);
      single_input <= 1'h0;
      $display("test open done");
    end
  endtask
  task t_sync;
    begin
      @(posedge clk);
      use_sync <= 1'h1;
      pulse(2);
      watch(30);
      chk(sc, 1'h0);
      @(posedge clk);
      sync_in <= 1'h1;
      pulse(2);
      watch(12);
      chk(position, `SGOC_POS_CLOSED);
      $display("test sync done");
    end
  endtask
  task t_local;
    begin
      pulse(0);
      watch(8);
      chk(so, 1'h0);
      remote_mode <= 1'h0;
      wr(`SGOC_REG_REMOTE_CMD, 32'h1);
      watch(8);
      chk(so, 1'h0);
      pulse(0);
      watch(12);
      chk(position, `SGOC_POS_OPEN);
      pulse(1);
      watch(12);
      chk(position, `SGOC_POS_CLOSED);
      remote_mode <= 1'h1;
      $display("test local done");
    end
  endtask
  task t_select;
    begin
      remote_select_mode <= 1'h1;
      wr(`SGOC_REG_REMOTE_CMD, 32'h1);
      watch(8);
      chk(so, 1'h0);
      wr(`SGOC_REG_REMOTE_CMD, 32'h4);
      wr(`SGOC_REG_REMOTE_CMD, 32'h1);
      watch(12);
      chk(position, `SGOC_POS_OPEN);
      remote_select_mode <= 1'h0;
      $display("test select done");
    end
  endtask
  task t_block_tout;
    begin
      close_block <= 1'h1;
      wr(`SGOC_REG_REMOTE_CMD, 32'h2);
      watch(8);
      chk(sc, 1'h0);
      rd(`SGOC_REG_STATUS);
      chk(rv[2], 1'h0);
      @(posedge clk);
      close_block <= 1'h0;
      stuck <= 1'h1;
      wr(`SGOC_REG_REMOTE_CMD, 32'h2);
      watch(40);
      chk(close_timeout, 1'h1);
      stuck <= 1'h0;
      $display("test block and timeout done");
    end
  endtask
  task t_clear;
    begin
      for (i = 2; i < 6; i = i + 1) begin
        rd(i[3:0]);
        chk(rv, (i == 2) ? 3 : (i == 4) ? 0 : 2);
      end
      wr(`SGOC_REG_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      for (i = 2; i < 6; i = i + 1) begin
        rd(i[3:0]);
        chk(rv, 32'h0);
      end
      $display("test clear done");
    end
  endtask
  task t_ready_open;
    begin
      @(posedge clk);
      open_block <= 1'h1;
      use_ready <= `SGOC_RDY_HIGH;
      rd(`SGOC_REG_STATUS);
      chk(rv[3:0], 4'h5);
      pulse(2);
      watch(30);
      chk(sc, 1'h0);
      @(posedge clk);
      ready_in <= 1'h1;
      pulse(2);
      watch(12);
      chk(position, `SGOC_POS_CLOSED);
      pulse(3);
      watch(8);
      chk(so, 1'h0);
      @(posedge clk);
      open_block <= 1'h0;
      pulse(3);
      watch(12);
      chk(position, `SGOC_POS_OPEN);
      @(posedge clk);
      use_ready <= `SGOC_RDY_LOW;
      object_type <= `SGOC_TYPE_MOTOR_DISC;
      pulse(2);
      watch(12);
      chk(position, `SGOC_POS_CLOSED);
      @(posedge clk);
      object_type <= `SGOC_TYPE_BREAKER;
      rd(`SGOC_REG_STATUS);
      chk(rv[1], 1'h0);
      @(posedge clk);
      ready_in <= 1'h0;
      rd(`SGOC_REG_STATUS);
      chk(rv[1], 1'h1);
      use_ready <= `SGOC_RDY_NOT_USED;
      $display("test ready and open block done");
    end
  endtask
  task t_type_force;
    begin
      object_type <= `SGOC_TYPE_WITHDRAWABLE;
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk);
        {cart_in_fb, cart_out_fb} <= i[1:0];
        @(posedge clk);
        #1 chk(cart_state, i);
      end
      @(posedge clk);
      object_type <= `SGOC_TYPE_EARTH_SWITCH;
      wr(`SGOC_REG_REMOTE_CMD, 32'h2);
      watch(8);
      chk(sc, 1'h0);
      chk(cart_state, `SGOC_CART_NOT_IN_USE);
      force_enable <= 1'h1;
      for (i = 0; i < 13; i = i + 1) begin
        @(posedge clk);
        force_state <= i[3:0];
        rd(`SGOC_REG_STATUS);
        chk(rv[15:12], i[3:0]);
      end
      $display("test type and force done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #40000;
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    {rst_n, reg_write, reg_read, stuck, single_input, use_sync} = 6'h0;
    {force_enable, remote_select_mode, local_open, local_close} = 4'h0;
    {auto_close, close_block, cart_in_fb, cart_out_fb, sync_in} = 5'h0;
    {auto_open, open_block, ready_in, use_ready} = 5'h0;
    {reg_addr, force_state, reg_wdata, rv} = 72'h0;
    remote_mode = 1'h1;
    object_type = `SGOC_TYPE_BREAKER;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_open;
    t_sync;
    t_local;
    t_select;
    t_block_tout;
    t_clear;
    t_ready_open;
    t_type_force;
    final_report;
  end
endmodule // test_switchgear_object_control
